// ===== rtl/clk_div_if.sv
/*
 * Interface carrying the divided clock enables between the sequencer
 * and its divider. Assumes one clock domain.
 */
`timescale 1ns/10ps
interface clk_div_if;
    logic core_tick;
    logic conv_tick;
    logic hold;

    modport divider
    (
        input  hold,
        output core_tick,
        output conv_tick
    );
    modport user
    (
        output hold,
        input  core_tick,
        input  conv_tick
    );
endinterface

// ===== rtl/clk_divider.sv
/*
 * Divides the oscillator clock into one-cycle ticks for the core
 * and for the converter/watchdog. Assumes clk is the oscillator.
 */
`timescale 1ns/10ps
`include "rst_seq_params.svh"
module clk_divider
#(
    parameter int CORE_DIV = `CORE_DIV,
    parameter int CONV_DIV = `CONV_DIV
)
(
    input  wire logic  clk,
    input  wire logic  rst_b,
    clk_div_if.divider div
);
    logic [3:0] core_cnt;
    logic [3:0] conv_cnt;
    wire        core_wrap = (core_cnt == 4'(CORE_DIV - 1));
    wire        conv_wrap = (conv_cnt == 4'(CONV_DIV - 1));

    // -----------------------------------------
    // Counters restart while the oscillator restarts
    // -----------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_cnt <= 4'h0;
            conv_cnt <= 4'h0;
        end
        else if (div.hold)
        begin
            core_cnt <= 4'h0;
            conv_cnt <= 4'h0;
        end
        else
        begin
            core_cnt <= core_wrap ? 4'h0 : core_cnt + 4'h1; // [RL1]
            conv_cnt <= conv_wrap ? 4'h0 : conv_cnt + 4'h1; // [RL1]
        end
    end

    assign div.core_tick = core_wrap & ~div.hold;
    assign div.conv_tick = conv_wrap & ~div.hold;

    // -----------------------------------------
    // Tick spacing helper: cycles since the last core tick
    // -----------------------------------------
    logic [3:0] core_gap;
    logic       core_seen;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_gap  <= 4'h0;
            core_seen <= 1'b0;
        end
        else if (div.hold)
        begin
            core_gap  <= 4'h0;
            core_seen <= 1'b0;
        end
        else if (div.core_tick)
        begin
            core_gap  <= 4'h0;
            core_seen <= 1'b1;
        end
        else
        begin
            core_gap  <= core_gap + 4'h1;
        end
    end

    core_div_a : assert property (@(posedge clk) disable iff (!rst_b)
        (div.core_tick && core_seen) |-> core_gap == 4'(CORE_DIV - 1)) // [RL1]
        else $error("core tick spacing wrong");
endmodule

// ===== rtl/reset_sequencer.sv
/*
 * Reset sequencer: merges pin, power-on and watchdog resets, stretches
 * them by a stabilisation delay, drives port pull-up, oscillator restart,
 * core start state and peripheral register reset values.
 * Assumes rst_b is the power-on detect and clk the oscillator clock.
 */
`timescale 1ns/10ps
`include "rst_seq_params.svh"
module reset_sequencer
#(
    parameter int STAB_CYCLES = `STAB_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ext_reset_b,
    input  wire logic        wdog_end,
    input  wire logic        stop_mode,
    input  wire logic        return_from_interrupt_instruction,
    output logic             core_tick,
    output logic             conv_tick,
    output logic             internal_reset,
    output logic             osc_restart,
    output logic             ports_pullup,
    output logic             core_run,
    output logic             stack_clear,
    output logic [11:0]      pc_load,
    output logic             nmi_context,
    output logic [7:0]       timer_count_init,
    output logic [6:0]       timer_presc_init,
    output logic [7:0]       timer_ctrl_init,
    output logic [7:0]       int_option_init,
    output logic [7:0]       portc_option_init,
    output logic [7:0]       wdog_reg_init
);
    // -----------------------------------------
    // Pin synchroniser
    // -----------------------------------------
    logic ext_meta;
    logic ext_sync;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end
        else
        begin
            ext_meta <= ext_reset_b; // [RL18]
            ext_sync <= ext_meta;    // [RL18]
        end
    end

    // -----------------------------------------
    // Source merge and delay counter
    // -----------------------------------------
    rst_seq_pkg::seq_state_t state;
    rst_seq_pkg::seq_state_t next_state;
    logic [11:0]             delay_cnt;
    logic                    wdog_req;

    // Pin low in any power state, or a latched watchdog request
    wire reset_req  = ~ext_sync | wdog_req;                    // [RL2] [RL3]
    wire delay_done = (delay_cnt == 12'(STAB_CYCLES - 1));     // [RL10]

    always_comb
    begin
        next_state = state;
        unique case (state)
            rst_seq_pkg::SEQ_HOLD:
                if (!reset_req)
                    next_state = rst_seq_pkg::SEQ_DELAY;       // [RL4]
            rst_seq_pkg::SEQ_DELAY:
                if (reset_req)
                    next_state = rst_seq_pkg::SEQ_HOLD;        // [RL5]
                else if (delay_done)
                    next_state = rst_seq_pkg::SEQ_INIT;        // [RL8]
            rst_seq_pkg::SEQ_INIT:
                if (reset_req)
                    next_state = rst_seq_pkg::SEQ_HOLD;
                else
                    next_state = rst_seq_pkg::SEQ_RUN;
            rst_seq_pkg::SEQ_RUN:
                if (reset_req)
                    next_state = rst_seq_pkg::SEQ_HOLD;        // [RL2]
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= rst_seq_pkg::SEQ_HOLD;                    // [RL9]
        else
            state <= next_state;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            delay_cnt <= 12'h000;
        else if (state != rst_seq_pkg::SEQ_DELAY || reset_req)
            delay_cnt <= 12'h000;                              // [RL18]
        else
            delay_cnt <= delay_cnt + 12'h001;                  // [RL10]
    end

    // Watchdog request held until the hold state consumes it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wdog_req <= 1'b0;
        else if (wdog_end && state == rst_seq_pkg::SEQ_RUN)
            wdog_req <= 1'b1;                                  // [RL11] [RL12]
        else if (state == rst_seq_pkg::SEQ_HOLD)
            wdog_req <= 1'b0;
    end

    // -----------------------------------------
    // Clock division
    // -----------------------------------------
    clk_div_if div_bus ();
    clk_divider u_div
    (
        .clk   (clk),
        .rst_b (rst_b),
        .div   (div_bus.divider)
    );
    assign div_bus.hold = (state == rst_seq_pkg::SEQ_HOLD);

    // -----------------------------------------
    // Outputs, all registered
    // -----------------------------------------
    wire in_reset   = (next_state != rst_seq_pkg::SEQ_RUN);
    wire enter_init = (next_state == rst_seq_pkg::SEQ_INIT);
    wire hold_next  = (next_state == rst_seq_pkg::SEQ_HOLD);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_tick      <= 1'b0;
            conv_tick      <= 1'b0;
            internal_reset <= 1'b1;
            osc_restart    <= 1'b1;
            ports_pullup   <= 1'b1;
            core_run       <= 1'b0;
            stack_clear    <= 1'b1;
        end
        else
        begin
            core_tick      <= div_bus.core_tick;               // [RL1]
            conv_tick      <= div_bus.conv_tick;               // [RL1]
            internal_reset <= in_reset;                        // [RL9] [RL11]
            // Stop or run/wait: oscillator restarts while held
            osc_restart    <= hold_next;                       // [RL6] [RL7]
            ports_pullup   <= in_reset;                        // [RL6] [RL7]
            core_run       <= ~in_reset;                       // [RL6]
            stack_clear    <= in_reset;                        // [RL13]
        end
    end

    // Vector and register init values, loaded at power-on reset and on entry to init
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pc_load           <= `RESET_VECTOR;
            timer_count_init  <= `TIMER_COUNT_RST;
            timer_presc_init  <= `TIMER_PRESC_RST;
            timer_ctrl_init   <= `TIMER_CTRL_RST;
            int_option_init   <= `INT_OPTION_RST;
            portc_option_init <= `PORTC_OPTION_RST;
            wdog_reg_init     <= `WDOG_REG_RST;
        end
        else if (enter_init)
        begin
            pc_load           <= `RESET_VECTOR;                // [RL13]
            timer_count_init  <= `TIMER_COUNT_RST;             // [RL16]
            timer_presc_init  <= `TIMER_PRESC_RST;             // [RL16]
            timer_ctrl_init   <= `TIMER_CTRL_RST;              // [RL16]
            int_option_init   <= `INT_OPTION_RST;              // [RL17]
            portc_option_init <= `PORTC_OPTION_RST;            // [RL17]
            wdog_reg_init     <= `WDOG_REG_RST;                // [RL17]
        end
    end

    // Non-maskable context from reset until return-from-interrupt
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            nmi_context <= 1'b1;
        else if (in_reset)
            nmi_context <= 1'b1;                               // [RL14]
        else if (return_from_interrupt_instruction)
            nmi_context <= 1'b0;                               // [RL15]
    end

    // -----------------------------------------
    // Checks
    // -----------------------------------------
    sequence pin_low_s;
        !ext_sync;
    endsequence

    sequence release_s;
        $rose(ext_sync) && !wdog_req;
    endsequence

    pin_holds_a : assert property (@(posedge clk) disable iff (!rst_b)
        pin_low_s |=> internal_reset) // [RL4]
        else $error("reset dropped while pin low");

    stab_delay_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state == rst_seq_pkg::SEQ_DELAY && delay_cnt == 12'h000 && !reset_req)
        |-> ##1 (internal_reset && !reset_req) [*8]) // [RL10]
        else $error("internal reset released early");

    release_time_a : assert property (@(posedge clk) disable iff (!rst_b)
        (delay_done && state == rst_seq_pkg::SEQ_DELAY && !reset_req)
        |=> ##1 !internal_reset || reset_req) // [RL8]
        else $error("reset not released after delay");

    short_pulse_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state == rst_seq_pkg::SEQ_RUN && !ext_sync) |=> ##1 internal_reset) // [RL5]
        else $error("short pulse gave no reset");

    wdog_reset_a : assert property (@(posedge clk) disable iff (!rst_b)
        (wdog_end && state == rst_seq_pkg::SEQ_RUN) |=> ##[1:2] ports_pullup) // [RL11]
        else $error("watchdog gave no reset");

    wdog_full_a : assert property (@(posedge clk) disable iff (!rst_b)
        (wdog_end && state == rst_seq_pkg::SEQ_RUN) |=> ##1
        (state == rst_seq_pkg::SEQ_HOLD || state == rst_seq_pkg::SEQ_DELAY)) // [RL12]
        else $error("watchdog skipped delay");

    vector_a : assert property (@(posedge clk) disable iff (!rst_b)
        $rose(core_run) |-> pc_load == 12'hffe && stack_clear == 1'b0) // [RL13]
        else $error("bad reset vector");

    nmi_start_a : assert property (@(posedge clk) disable iff (!rst_b)
        $rose(core_run) |-> nmi_context) // [RL14]
        else $error("not in nmi context at start");

    return_from_interrupt_instruction_a : assert property (@(posedge clk) disable iff (!rst_b)
        (core_run && return_from_interrupt_instruction && !in_reset) |=> !nmi_context) // [RL15]
        else $error("return did not leave nmi context");

    init_vals_a : assert property (@(posedge clk) disable iff (!rst_b)
        $rose(core_run) |-> timer_presc_init == 7'h7f && wdog_reg_init == 8'hfe
        && portc_option_init == 8'hff && int_option_init == 8'h00) // [RL16] [RL17]
        else $error("bad register init values");

    stop_reset_a : assert property (@(posedge clk) disable iff (!rst_b)
        (stop_mode && !ext_sync) |=> (osc_restart && ports_pullup)) // [RL7] [RL3]
        else $error("stop reset not honoured");

    sync_lag_a : assert property (@(posedge clk) disable iff (!rst_b)
        release_s |-> $past(ext_reset_b, 2)) // [RL18]
        else $error("synchroniser depth wrong");
endmodule

// ===== rtl/rst_seq_params.svh
/*
 * Constants for the clock divider and reset sequencer: divide ratios,
 * stabilisation count, reset vector and register reset values.
 * Assumes it is included by bare name from rtl/ sources.
 */
// What this block does
// RL1: Core clock is oscillator divided by 13; converter/watchdog clock divided by 12.
// RL2: Reset enters from external pin, power-on detect, or watchdog end of count.
// RL3: External reset is active low and accepted in run, wait and stop.
// RL4: Reset state holds as long as the external pin stays low.
// RL5: Internal reset stretches the request so short pulses give a full reset.
// RL6: Reset in run/wait halts execution, pulls up ports, restarts oscillator.
// RL7: Reset in stop starts the oscillator and pulls up all ports.
// RL8: Initialisation begins only after the internal delay expires after release.
// RL9: Power-on holds reset, pulled-up ports, no execution until delay ends.
// RL10: On-chip counter releases internal reset 2048 cycles after external release.
// RL11: Watchdog end of count asserts internal reset, reinitialising the watchdog.
// RL12: Watchdog reset restarts exactly like pin reset, with full delay.
// RL13: Reset clears return stack and loads program counter with vector 0FFEh.
// RL14: After reset interrupt flag set so core runs in non-maskable context.
// RL15: Software ends init with return-from-interrupt; device then resumes normal context.
// RL16: Reset loads timer counters FFh, prescalers 7Fh, status/control 00h.
// RL17: Reset clears interrupt option, port C option FFh, watchdog register FEh.
// RL18: External reset passes a two-stage synchroniser before driving the delay counter.
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH

`define CORE_DIV          13
`define CONV_DIV          12
`define STAB_CYCLES       2048
`define RESET_VECTOR      12'hffe
`define TIMER_COUNT_RST   8'hff
`define TIMER_PRESC_RST   7'h7f
`define TIMER_CTRL_RST    8'h00
`define INT_OPTION_RST    8'h00
`define PORTC_OPTION_RST  8'hff
`define WDOG_REG_RST      8'hfe

`endif

// ===== rtl/rst_seq_pkg.sv
/*
 * Types for the reset sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rst_seq_pkg;

    typedef enum logic [1:0]
    {
        SEQ_HOLD  = 2'b00,
        SEQ_DELAY = 2'b01,
        SEQ_INIT  = 2'b11,
        SEQ_RUN   = 2'b10
    } seq_state_t;

endpackage

// ===== tb/board_reset_model.sv
/*
 * Board reset model: drives the active-low reset pin for a given count.
 * Assumes the pin has a pull-up, so it idles high between pulses.
 */
`timescale 1ns/10ps
module board_reset_model
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output logic            ext_reset_b
);
    logic [7:0] cnt = 8'h00;

    always @(negedge clk)
    begin
        if (go)
            cnt <= len;
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end

    // Low while a pulse runs, pulled high otherwise
    assign ext_reset_b = (cnt == 8'h00);
endmodule

// ===== tb/test_clock_divide_and_reset_sequencer.sv
/*
 * Self-checking bench for the reset sequencer, random and corner resets.
 * Assumes a short stabilisation count and the board reset model.
 */
`timescale 1ns/10ps
module test_clock_divide_and_reset_sequencer;
    localparam int STAB = 16;
    logic        clk, rst_b, ext_reset_b, wdog_end, stop_mode, rfi, go;
    logic [7:0]  len;
    logic        core_tick, conv_tick, internal_reset, osc_restart;
    logic        ports_pullup, core_run, stack_clear, nmi_context;
    logic [11:0] pc_load;
    logic [7:0]  t_cnt, t_ctl, int_opt, pc_opt, wd_reg;
    logic [6:0]  t_pre;
    int          err_total, cmp_count, seed;

    // ------------------------------------------------
    // Instances
    // ------------------------------------------------
    board_reset_model brd_u (.clk(clk), .go(go), .len(len), .ext_reset_b(ext_reset_b));

    reset_sequencer #(.STAB_CYCLES(STAB)) dut_u
    (
        .clk(clk), .rst_b(rst_b), .ext_reset_b(ext_reset_b), .wdog_end(wdog_end),
        .stop_mode(stop_mode), .return_from_interrupt_instruction(rfi),
        .core_tick(core_tick), .conv_tick(conv_tick), .internal_reset(internal_reset),
        .osc_restart(osc_restart), .ports_pullup(ports_pullup), .core_run(core_run),
        .stack_clear(stack_clear), .pc_load(pc_load), .nmi_context(nmi_context),
        .timer_count_init(t_cnt), .timer_presc_init(t_pre), .timer_ctrl_init(t_ctl),
        .int_option_init(int_opt), .portc_option_init(pc_opt), .wdog_reg_init(wd_reg)
    );

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task tally_and_finish;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Counts cycles until the core runs again; must not be early or late
    task wait_run;
        int n;
        n = 0;
        // A short pulse reaches the core only after the synchroniser
        while (core_run !== 1'b0 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        chk(core_run, 0);
        n = 0;
        while (core_run !== 1'b1 && n < STAB + 10)
        begin
            @(negedge clk);
            n++;
        end
        chk(core_run, 1);
        chk(n >= STAB - 2, 1);
    endtask

    task pin_pulse(input logic [7:0] l);
        int n;
        n = 0;
        len <= l;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        @(negedge clk);
        while (ext_reset_b !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
            if (n == 6)
            begin
                chk(internal_reset, 1);
                chk(osc_restart, 1);
                chk(ports_pullup, 1);
            end
            if (l > 9 && n == l - 1)
                chk(core_run, 0);
        end
        wait_run();
    endtask

    task wdog_reset;
        wdog_end <= 1'b1;
        @(negedge clk);
        wdog_end <= 1'b0;
        repeat (2) @(negedge clk);
        chk(internal_reset, 1);
        wait_run();
    endtask

    task nmi_check;
        chk(nmi_context, 1);
        rfi <= 1'b1;
        @(negedge clk);
        rfi <= 1'b0;
        repeat (2) @(negedge clk);
        chk(nmi_context, 0);
    endtask

    task gap(input bit conv, input int e);
        int n;
        n = 0;
        while ((conv ? conv_tick : core_tick) !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((conv ? conv_tick : core_tick) !== 1'b1 && n < 40);
        chk(16'(n), 16'(e));
    endtask

    // ------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        #100000;
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        seed = 32'h65c3;
        err_total = 0;
        cmp_count = 0;
        {rst_b, wdog_end, stop_mode, rfi, go, len} = '0;
        repeat (20) @(negedge clk);
        chk(internal_reset, 1);
        chk(ports_pullup, 1);
        chk(core_run, 0);
        chk(stack_clear, 1);
        chk({4'h0, pc_load}, 16'h0ffe);
        chk({t_cnt, 1'b0, t_pre}, {8'hff, 8'h7f});
        chk({8'h00, t_ctl}, 16'h0000);
        chk({8'h00, int_opt}, 16'h0000);
        chk({pc_opt, wd_reg}, 16'hfffe);
        rst_b <= 1'b1;
        wait_run();
        nmi_check();
        gap(1'b0, 13);
        gap(1'b1, 12);
        pin_pulse(8'h02);
        nmi_check();
        repeat (8)
        begin
            stop_mode <= 1'($random(seed));
            if ($random(seed) & 1)
                pin_pulse(8'(2 + ($unsigned($random(seed)) % 40)));
            else
                wdog_reset();
            nmi_check();
        end
        tally_and_finish();
    end
endmodule
